// ### core/resp_pkg.sv
// Purpose: constants for the test-link response message generator
// Assumes: byte-wide request and answer streams, one clock, no bus
// Notes: message identifiers are decimal values on the link
//
// Summary of operation
// R1 - every table request gets its matching response table message
// R2 - status table response, id 091, sent only for status table request
// R3 - status octet: upper nibble zero, bits 3..0 sacch, tch, bcch, sdcch
// R4 - power level response octet 2 coded as power command octet 2
// R5 - short message request with stored message answers id 101
// R6 - message field: null, 12 addr, 12 centre, pid, dcs, 7 stamp, len, data
// R7 - short addresses padded with null bytes to twelve
// R8 - short message request without stored message answers id 102
// R9 - malfunction error 240 only in reply to a received message
// R10 - malfunction octet 2 carries the maker-defined error code
// R11 - intact but uninterpretable message answered with error 241
// R12 - error 241 from the simulator resends the last transmitted message
// R13 - understood but unsupported function answered with error 242
// R14 - request for a state already held answered with error 242
// R15 - reset command 255 performs a full power-on-equivalent reset; an sm_received in the same cycle leaves sm_have_q set
// R16 - identifier in octet 1, payload octets follow in order
package resp_pkg;
  localparam logic [7:0] ID_VOL_UP = 8'h33;
  localparam logic [7:0] ID_VOL_DOWN = 8'h34;
  localparam logic [7:0] ID_REQ_STATUS = 8'h35;
  localparam logic [7:0] ID_REQ_IND = 8'h36;
  localparam logic [7:0] ID_REQ_POWER = 8'h37;
  localparam logic [7:0] ID_REQ_BELL = 8'h38;
  localparam logic [7:0] ID_REQ_SM = 8'h39;
  localparam logic [7:0] ID_KEYS = 8'h3A;
  localparam logic [7:0] ID_BELL_ON = 8'h3C;
  localparam logic [7:0] ID_BELL_OFF = 8'h3D;
  localparam logic [7:0] ID_HOOK_ON = 8'h40;
  localparam logic [7:0] ID_HOOK_OFF = 8'h41;
  localparam logic [7:0] ID_BEARER = 8'h46;
  localparam logic [7:0] ID_SET_POWER = 8'h50;
  localparam logic [7:0] ID_RSP_STATUS = 8'h5B;
  localparam logic [7:0] ID_RSP_IND = 8'h5C;
  localparam logic [7:0] ID_RSP_POWER = 8'h5D;
  localparam logic [7:0] ID_SM_REPORT = 8'h65;
  localparam logic [7:0] ID_NO_SM = 8'h66;
  localparam logic [7:0] ID_ERR_MALF = 8'hF0;
  localparam logic [7:0] ID_ERR_NREC = 8'hF1;
  localparam logic [7:0] ID_ERR_NPERF = 8'hF2;
  localparam logic [7:0] ID_RESET = 8'hFF;
  localparam logic [7:0] NULL_BYTE = 8'h00;
  localparam logic [3:0] SPARE_NIBBLE = 4'h0;
  localparam int ADDR_LEN = 12;
  localparam int STAMP_LEN = 7;
  localparam int DATA_MAX = 140;
  // field offsets inside the stored short message (octet 2 onward)
  localparam int OFS_ORIG = 1;
  localparam int OFS_CENTRE = OFS_ORIG + ADDR_LEN;
  localparam int OFS_PID = OFS_CENTRE + ADDR_LEN;
  localparam int OFS_DCS = OFS_PID + 1;
  localparam int OFS_STAMP = OFS_DCS + 1;
  localparam int OFS_UDL = OFS_STAMP + STAMP_LEN;
  localparam int OFS_DATA = OFS_UDL + 1;
  localparam int SM_LEN = OFS_DATA + DATA_MAX;
  localparam int SM_AW = 8;
  localparam logic [SM_AW-1:0] SM_LAST = SM_AW'(SM_LEN - 1);
  // longest message held for resend: identifier plus one octet
  localparam int HOLD_LEN = 2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ID = 3'b001,
    ST_OCT2 = 3'b011,
    ST_SM = 3'b010,
    ST_RESET = 3'b110
  } tx_state_t;
endpackage : resp_pkg

// ### core/sm_store.sv
// Purpose: short message store with address padding and ordered readout
// Assumes: writer loads fields by offset; reader walks octets in order
// Notes: unused address bytes read as null regardless of stored contents
`timescale 1ns/1ps
`default_nettype none
module sm_store
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic [resp_pkg::SM_AW-1:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [3:0] orig_len,
  input wire logic [3:0] centre_len,
  input wire logic [resp_pkg::SM_AW-1:0] rd_idx,
  output logic [7:0] rd_data,
  output logic [resp_pkg::SM_AW-1:0] msg_len
);
  import resp_pkg::*;
  logic [7:0] mem [0:SM_LEN-1];
  logic [3:0] orig_len_q;
  logic [3:0] centre_len_q;
  logic [7:0] udl_q;
  logic [7:0] raw;

  // array has no reset; null padding and lengths make stale bytes harmless
  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[wr_idx] <= wr_data;
  end

  // address lengths captured with each write so padding follows the load
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      orig_len_q <= 4'h0;
      centre_len_q <= 4'h0;
      udl_q <= 8'h00;
    end
    else if (clear)
    begin
      orig_len_q <= 4'h0;
      centre_len_q <= 4'h0;
      udl_q <= 8'h00;
    end
    else if (wr_en)
    begin
      orig_len_q <= orig_len;
      centre_len_q <= centre_len;
      if (wr_idx == SM_AW'(OFS_UDL))
        udl_q <= (wr_data > 8'(DATA_MAX)) ? 8'(DATA_MAX) : wr_data;
    end
  end

  assign raw = mem[rd_idx];

  // pad short address slots with null
  always_comb
  begin
    rd_data = raw;
    if (rd_idx < SM_AW'(OFS_ORIG))
      rd_data = NULL_BYTE; // R6
    else if (rd_idx < SM_AW'(OFS_CENTRE))
    begin
      if (rd_idx - SM_AW'(OFS_ORIG) >= SM_AW'(orig_len_q))
        rd_data = NULL_BYTE; // R7
    end
    else if (rd_idx < SM_AW'(OFS_PID))
    begin
      if (rd_idx - SM_AW'(OFS_CENTRE) >= SM_AW'(centre_len_q))
        rd_data = NULL_BYTE; // R7
    end
  end

  // fixed header plus user data length octets
  assign msg_len = SM_AW'(OFS_DATA) + udl_q; // R6
endmodule : sm_store
`default_nettype wire

// ### core/test_link_response_messages.sv
// Purpose: answers simulator requests on the byte-wide test control link
// Assumes: one request byte per rx_valid pulse; tx_ready stalls output
// Notes: status, power and error code come in as plain level ports
`timescale 1ns/1ps
`default_nettype none
module test_link_response_messages
(
  input wire logic clk,
  input wire logic resetn,
  // request stream from the simulator
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // answer stream to the simulator
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  // live status from the unit
  input wire logic sacch_link_up,
  input wire logic tch_speech_up,
  input wire logic bcch_listening,
  input wire logic sdcch_up,
  input wire logic [7:0] power_level,
  input wire logic [7:0] indication_field,
  input wire logic bell_active,
  input wire logic [3:0] unsupported_mask,
  // function hooks
  input wire logic malfunction,
  input wire logic [7:0] malfunction_code,
  // short message loading from the unit
  input wire logic sm_wr_en,
  input wire logic [resp_pkg::SM_AW-1:0] sm_wr_idx,
  input wire logic [7:0] sm_wr_data,
  input wire logic [3:0] sm_orig_len,
  input wire logic [3:0] sm_centre_len,
  input wire logic sm_received,
  // commands to the unit
  output logic hook_off_q_out,
  output logic full_reset_pulse
);
  import resp_pkg::*;
  tx_state_t state_q;
  logic [7:0] id_q;
  logic [7:0] oct2_q;
  logic has_oct2_q;
  logic [7:0] last_id_q;
  logic [7:0] last_oct2_q;
  logic last_has2_q;
  logic sm_q;
  logic sm_have_q;
  logic [SM_AW-1:0] idx_q;
  logic [SM_AW-1:0] sm_len;
  logic [7:0] sm_byte;
  logic hook_q;
  logic last_sm_q;
  logic rx_ready_q;
  logic tx_valid_q;
  logic [7:0] tx_data_q;
  logic tx_last_q;
  logic rst_q;
  logic accept;
  logic soft_reset;
  logic [7:0] nx_id;
  logic [7:0] nx_oct2;
  logic nx_has2;
  logic nx_sm;
  logic nx_replay;

  assign accept = rx_valid && rx_ready_q;
  assign soft_reset = accept && (rx_data == ID_RESET); // R15

  // ready comes from a flop and rises one cycle after the answer has
  // drained; a request can then never overtake a byte still pending
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rx_ready_q <= 1'b1;
    else
      rx_ready_q <= (state_q == ST_IDLE) && !tx_valid_q && !accept; // R1
  end

  sm_store u_store (
    .clk(clk),
    .resetn(resetn),
    .clear(soft_reset),
    .wr_en(sm_wr_en),
    .wr_idx(sm_wr_idx),
    .wr_data(sm_wr_data),
    .orig_len(sm_orig_len),
    .centre_len(sm_centre_len),
    .rd_idx(idx_q),
    .rd_data(sm_byte),
    .msg_len(sm_len)
  );

  // decode one request into the answer it needs; answers only follow
  // received messages, so nothing here ever starts spontaneously
  always_comb
  begin
    nx_id = ID_ERR_NREC;
    nx_oct2 = NULL_BYTE;
    nx_has2 = 1'b0;
    nx_sm = 1'b0;
    nx_replay = 1'b0;
    if (malfunction)
    begin
      nx_id = ID_ERR_MALF; // R9
      nx_oct2 = malfunction_code; // R10
      nx_has2 = 1'b1;
    end
    else if (rx_data == ID_REQ_STATUS)
    begin
      nx_id = ID_RSP_STATUS; // R1 R2
      nx_oct2 = {SPARE_NIBBLE, sacch_link_up, tch_speech_up,
                 bcch_listening, sdcch_up}; // R3
      nx_has2 = 1'b1;
    end
    else if (rx_data == ID_REQ_IND)
    begin
      nx_id = ID_RSP_IND; // R1
      nx_oct2 = indication_field;
      nx_has2 = 1'b1;
    end
    else if (rx_data == ID_REQ_POWER)
    begin
      nx_id = ID_RSP_POWER; // R1
      nx_oct2 = power_level; // R4
      nx_has2 = 1'b1;
    end
    else if (rx_data == ID_REQ_BELL)
      nx_id = bell_active ? ID_BELL_ON : ID_BELL_OFF;
    else if (rx_data == ID_REQ_SM)
    begin
      nx_id = sm_have_q ? ID_SM_REPORT : ID_NO_SM; // R5 R8
      nx_sm = sm_have_q;
    end
    else if (rx_data == ID_ERR_NREC)
      nx_replay = 1'b1; // R12
    else if (rx_data == ID_HOOK_OFF)
      nx_id = hook_q ? ID_ERR_NPERF : NULL_BYTE; // R14
    else if (rx_data == ID_HOOK_ON)
      nx_id = hook_q ? NULL_BYTE : ID_ERR_NPERF; // R14
    else if (rx_data == ID_VOL_UP || rx_data == ID_VOL_DOWN)
      nx_id = unsupported_mask[0] ? ID_ERR_NPERF : NULL_BYTE; // R13
    else if (rx_data == ID_KEYS)
      nx_id = unsupported_mask[1] ? ID_ERR_NPERF : NULL_BYTE; // R13
    else if (rx_data == ID_BEARER)
      nx_id = unsupported_mask[2] ? ID_ERR_NPERF : NULL_BYTE; // R13
    else if (rx_data == ID_SET_POWER)
      nx_id = unsupported_mask[3] ? ID_ERR_NPERF : NULL_BYTE; // R13
    else
      nx_id = ID_ERR_NREC; // R11
  end

  // transmit sequencer; a zero identifier means a silent accept
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_IDLE;
      id_q <= 8'h00;
      oct2_q <= 8'h00;
      has_oct2_q <= 1'b0;
      sm_q <= 1'b0;
      idx_q <= '0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          idx_q <= '0;
          if (soft_reset)
            state_q <= ST_RESET; // R15
          else if (accept && nx_replay)
          begin
            id_q <= last_id_q; // R12
            oct2_q <= last_oct2_q;
            has_oct2_q <= last_has2_q;
            sm_q <= last_sm_q;
            if (last_id_q != NULL_BYTE)
              state_q <= ST_ID;
          end
          else if (accept && nx_id != NULL_BYTE)
          begin
            id_q <= nx_id;
            oct2_q <= nx_oct2;
            has_oct2_q <= nx_has2;
            sm_q <= nx_sm;
            state_q <= ST_ID;
          end
        end
        ST_ID:
          if (tx_ready || !tx_valid_q)
            state_q <= ST_OCT2;
        ST_OCT2:
          if (tx_ready)
          begin
            if (sm_q)
            begin
              state_q <= ST_SM;
              idx_q <= idx_q + SM_AW'(1); // R6
            end
            else
              state_q <= ST_IDLE;
          end
        ST_SM:
          // field byte at idx_q is loaded as the one before it is taken
          if (tx_ready || !tx_valid_q)
          begin
            if (idx_q == sm_len - SM_AW'(1) || idx_q == SM_LAST)
              state_q <= ST_IDLE;
            else
              idx_q <= idx_q + SM_AW'(1); // R6
          end
        ST_RESET:
          state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // output register: identifier first, then payload in order
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_last_q <= 1'b0;
    end
    else if (state_q == ST_ID && (tx_ready || !tx_valid_q))
    begin
      tx_valid_q <= 1'b1;
      tx_data_q <= id_q; // R16
      tx_last_q <= !has_oct2_q && !sm_q;
    end
    else if (state_q == ST_OCT2 && tx_ready)
    begin
      // a report runs straight on into its field, with no gap in valid
      tx_valid_q <= has_oct2_q || sm_q;
      tx_data_q <= sm_q ? sm_byte : oct2_q; // R16
      tx_last_q <= has_oct2_q;
    end
    else if (state_q == ST_SM && (tx_ready || !tx_valid_q))
    begin
      tx_valid_q <= 1'b1;
      tx_data_q <= sm_byte; // R6
      tx_last_q <= (idx_q == sm_len - SM_AW'(1)) || (idx_q == SM_LAST);
    end
    else if (tx_ready || soft_reset)
      tx_valid_q <= 1'b0;
  end

  // last answer held for resend; a report is rebuilt from the store
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      last_id_q <= 8'h00;
      last_oct2_q <= 8'h00;
      last_has2_q <= 1'b0;
      last_sm_q <= 1'b0;
    end
    else if (soft_reset)
      last_id_q <= 8'h00;
    else if (state_q == ST_ID && (tx_ready || !tx_valid_q))
    begin
      last_id_q <= id_q; // R12
      last_oct2_q <= oct2_q;
      last_has2_q <= has_oct2_q;
      last_sm_q <= sm_q;
    end
  end

  // unit state: hook position, message presence, reset pulse
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hook_q <= 1'b0;
      sm_have_q <= 1'b0;
      rst_q <= 1'b0;
    end
    else
    begin
      rst_q <= soft_reset; // R15
      if (soft_reset)
        hook_q <= 1'b0; // R15
      else if (accept && !malfunction && rx_data == ID_HOOK_OFF)
        hook_q <= 1'b1;
      else if (accept && !malfunction && rx_data == ID_HOOK_ON)
        hook_q <= 1'b0;
      // a fresh arrival beats the reset clear in the same cycle, since
      // the unit still holds that message
      if (sm_received)
        sm_have_q <= 1'b1;
      else if (soft_reset)
        sm_have_q <= 1'b0; // R15
    end
  end

  assign rx_ready = rx_ready_q;
  assign tx_valid = tx_valid_q;
  assign tx_data = tx_data_q;
  assign tx_last = tx_last_q;
  assign hook_off_q_out = hook_q;
  assign full_reset_pulse = rst_q;
endmodule : test_link_response_messages
`default_nettype wire

// ### dv/link_sink.sv
// Purpose: answer sink standing in for the simulator's receive side
// Assumes: one clock; tx_ready is registered
// Notes: slow mode stalls every other cycle so bytes must hold
`timescale 1ns/1ps
`default_nettype none
module link_sink
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic slow,
  output logic tx_ready
);
  // stall pattern; never ready in reset, so nothing is lost there
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      tx_ready <= 1'b0;
    else
      tx_ready <= slow ? ~tx_ready : 1'b1;
  end
endmodule : link_sink
`default_nettype wire

// ### dv/resp_checker.sv
// Purpose: port-level checks of the response message generator
// Assumes: status and power inputs are steady while answers go out
// Notes: answer latency window is two to three edges after accept
`timescale 1ns/1ps
`default_nettype none
module resp_checker
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_ready,
  input wire logic sacch_link_up,
  input wire logic tch_speech_up,
  input wire logic bcch_listening,
  input wire logic sdcch_up,
  input wire logic [7:0] power_level,
  input wire logic malfunction,
  input wire logic [7:0] malfunction_code,
  input wire logic hook_off_q_out,
  input wire logic full_reset_pulse
);
  import resp_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic take;
  logic [2:0] since_q;
  assign take = rx_valid && rx_ready;
  // cycles since the last accepted request, saturating at seven
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      since_q <= 3'h7;
    else
      since_q <= take ? 3'h0 : (since_q == 3'h7 ? 3'h7 : since_q + 3'h1);
  end
  status_ans_a: assert property (
    take && rx_data == ID_REQ_STATUS && !malfunction |->
    ##[2:3] tx_valid && tx_data == ID_RSP_STATUS)
    else $error("status request not answered");
  status_oct_a: assert property (
    tx_valid && tx_ready && tx_data == ID_RSP_STATUS && !tx_last |=>
    tx_valid && tx_last && tx_data == {SPARE_NIBBLE, sacch_link_up,
    tch_speech_up, bcch_listening, sdcch_up})
    else $error("status octet wrong");
  power_oct_a: assert property (
    tx_valid && tx_ready && tx_data == ID_RSP_POWER && !tx_last |=>
    tx_valid && tx_last && tx_data == power_level)
    else $error("power octet wrong");
  malf_ans_a: assert property (
    take && malfunction |-> ##[2:3] tx_valid && tx_data == ID_ERR_MALF)
    else $error("malfunction not reported");
  malf_code_a: assert property (
    tx_valid && tx_ready && tx_data == ID_ERR_MALF && !tx_last |=>
    tx_valid && tx_last && tx_data == malfunction_code)
    else $error("malfunction code wrong");
  no_spont_a: assert property (
    $rose(tx_valid) |-> since_q < 3'h3)
    else $error("answer without request");
  byte_hold_a: assert property (
    tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("answer byte dropped");
  busy_refuse_a: assert property (
    tx_valid |-> !rx_ready)
    else $error("request taken while answering");
  unknown_id_a: assert property (
    take && rx_data == 8'h20 && !malfunction |->
    ##[2:3] tx_valid && tx_data == ID_ERR_NREC && tx_last)
    else $error("unknown id not refused");
  reset_cmd_a: assert property (
    take && rx_data == ID_RESET && !malfunction |-> ##[1:2] full_reset_pulse)
    else $error("reset command ignored");
  reset_pulse_a: assert property (
    full_reset_pulse |=> !full_reset_pulse && !hook_off_q_out)
    else $error("reset pulse or hook wrong");
endmodule : resp_checker
bind test_link_response_messages resp_checker chk_i (.clk, .resetn,
  .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_last, .tx_ready,
  .sacch_link_up, .tch_speech_up, .bcch_listening, .sdcch_up, .power_level,
  .malfunction, .malfunction_code, .hook_off_q_out, .full_reset_pulse);
`default_nettype wire

// ### dv/tb.sv
// Purpose: directed test of the response message generator
// Assumes: answers collected at negedge, requests driven at posedge
// Notes: resend is tried on a table and on a stored message report
`timescale 1ns/1ps
`default_nettype none
module tb;
  import resp_pkg::*;
  logic clk, resetn, rx_valid, rx_ready, tx_valid, tx_last, tx_ready, slow;
  logic sacch_link_up, tch_speech_up, bcch_listening, sdcch_up, bell_active;
  logic malfunction, sm_wr_en, sm_received, hook_off_q_out, full_reset_pulse;
  logic [7:0] rx_data, tx_data, power_level, indication_field;
  logic [7:0] malfunction_code, sm_wr_data;
  logic [3:0] unsupported_mask, sm_orig_len, sm_centre_len;
  logic [SM_AW-1:0] sm_wr_idx;
  logic [7:0] got[$];
  logic [7:0] exp[$];
  int error_cnt = 0;
  int comparisons = 0;
  test_link_response_messages uut (.clk, .resetn, .rx_valid, .rx_data,
    .rx_ready, .tx_valid, .tx_data, .tx_last, .tx_ready, .sacch_link_up,
    .tch_speech_up, .bcch_listening, .sdcch_up, .power_level,
    .indication_field, .bell_active, .unsupported_mask, .malfunction,
    .malfunction_code, .sm_wr_en, .sm_wr_idx, .sm_wr_data, .sm_orig_len,
    .sm_centre_len, .sm_received, .hook_off_q_out, .full_reset_pulse);
  link_sink sink (.clk, .resetn, .slow, .tx_ready);
  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task conclude;
    begin
      if (error_cnt == 0 && comparisons > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask : conclude
  task hang;
    begin
      error_cnt++;
      conclude;
    end
  endtask : hang
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] want);
    begin
      comparisons++;
      if (seen !== want)
      begin
        error_cnt++;
        $display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
      end
    end
  endtask : chk
  // request held until seen ready, so it is taken exactly once
  task req(input logic [7:0] id);
    int i;
    begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= id;
      @(negedge clk);
      for (i = 0; i < 300 && rx_ready !== 1'b1; i++)
        @(negedge clk);
      if (i == 300)
        hang;
      @(posedge clk);
      rx_valid <= 1'b0;
    end
  endtask : req
  // gather one whole answer and compare it with exp
  task msg(input string nm);
    int i;
    logic done;
    begin
      got = {};
      done = 1'b0;
      for (i = 0; i < 400 && !done; i++)
      begin
        @(negedge clk);
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
        begin
          got.push_back(tx_data);
          done = (tx_last === 1'b1);
        end
      end
      if (!done)
        hang;
      chk({nm, " len"}, 8'(got.size()), 8'(exp.size()));
      for (i = 0; i < got.size() && i < exp.size(); i++)
        chk(nm, got[i], exp[i]);
    end
  endtask : msg
  // a silent accept must put nothing on the answer stream
  task quiet(input string nm);
    int n;
    begin
      n = 0;
      repeat (8)
      begin
        @(negedge clk);
        n += (tx_valid !== 1'b0);
      end
      chk(nm, 8'(n), 8'h00);
    end
  endtask : quiet
  task t_tables;
    begin
      req(ID_REQ_STATUS);
      exp = '{ID_RSP_STATUS, 8'h0A};
      msg("status");
      req(ID_ERR_NREC);
      msg("resend");
      @(posedge clk);
      slow <= 1'b1;
      req(ID_REQ_POWER);
      exp = '{ID_RSP_POWER, 8'h1F};
      msg("power");
      req(ID_REQ_IND);
      exp = '{ID_RSP_IND, 8'hA5};
      msg("indication");
      req(ID_REQ_BELL);
      exp = '{ID_BELL_OFF};
      msg("bell");
      @(posedge clk);
      bell_active <= 1'b1;
      req(ID_REQ_BELL);
      exp = '{ID_BELL_ON};
      msg("bell on");
    end
  endtask : t_tables
  task t_sm;
    int i;
    begin
      req(ID_REQ_SM);
      exp = '{ID_NO_SM};
      msg("no message");
      for (i = OFS_ORIG; i < OFS_DATA + 2; i++)
      begin
        @(posedge clk);
        sm_wr_en <= 1'b1;
        sm_wr_idx <= SM_AW'(i);
        sm_wr_data <= (i == OFS_UDL) ? 8'h02 : 8'hAA;
      end
      @(posedge clk);
      sm_wr_en <= 1'b0;
      sm_received <= 1'b1;
      exp = '{ID_SM_REPORT, NULL_BYTE};
      for (i = OFS_ORIG; i < OFS_DATA + 2; i++)
        exp.push_back((i >= OFS_ORIG + 3 && i < OFS_CENTRE) ? NULL_BYTE :
          (i == OFS_UDL) ? 8'h02 : 8'hAA);
      req(ID_REQ_SM);
      msg("report");
      req(ID_ERR_NREC);
      msg("report resend");
    end
  endtask : t_sm
  task t_err;
    begin
      @(posedge clk);
      malfunction <= 1'b1;
      req(ID_REQ_STATUS);
      exp = '{ID_ERR_MALF, 8'h5A};
      msg("malfunction");
      @(posedge clk);
      malfunction <= 1'b0;
      unsupported_mask <= 4'h1;
      req(8'h20);
      exp = '{ID_ERR_NREC};
      msg("unknown");
      req(ID_VOL_UP);
      exp = '{ID_ERR_NPERF};
      msg("unsupported");
      req(ID_HOOK_OFF);
      quiet("hook off");
      chk("hook state", {7'h00, hook_off_q_out}, 8'h01);
      req(ID_HOOK_OFF);
      exp = '{ID_ERR_NPERF};
      msg("hook off again");
      req(ID_HOOK_ON);
      quiet("hook on");
      req(ID_HOOK_ON);
      msg("hook on again");
      req(ID_KEYS);
      quiet("keys");
      @(posedge clk);
      unsupported_mask <= 4'hE;
      req(ID_BEARER);
      msg("bearer");
      req(ID_SET_POWER);
      msg("set power");
      req(ID_HOOK_OFF);
      quiet("hook off last");
    end
  endtask : t_err
  task t_reset;
    int n;
    begin
      @(posedge clk);
      sm_received <= 1'b0;
      req(ID_RESET);
      n = 0;
      repeat (6)
      begin
        @(negedge clk);
        n += (full_reset_pulse === 1'b1);
      end
      chk("reset pulses", 8'(n), 8'h01);
      chk("hook cleared", {7'h00, hook_off_q_out}, 8'h00);
      req(ID_REQ_SM);
      exp = '{ID_NO_SM};
      msg("after reset");
    end
  endtask : t_reset
  // main sequence; silent accepts are judged by quiet, not by msg
  initial
  begin
    resetn = 1'b0;
    {rx_valid, slow, malfunction, sm_wr_en, sm_received, bell_active} = '0;
    {sacch_link_up, tch_speech_up, bcch_listening, sdcch_up} = 4'hA;
    {rx_data, sm_wr_data, sm_wr_idx, unsupported_mask} = '0;
    power_level = 8'h1F;
    indication_field = 8'hA5;
    malfunction_code = 8'h5A;
    sm_orig_len = 4'h3;
    sm_centre_len = 4'hC;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_tables;
    t_sm;
    t_err;
    t_reset;
    conclude;
  end
endmodule : tb
`default_nettype wire
